// ### pmbw_core.sv
// Purpose: write data path of a bus master finishing a burst that the target
//          accepted at 32 bits, fed by 64-bit local words
// Assumes: address phase and width request were done before start_i
// Notes: the local word presented with start_i is taken in that cycle
//
// Summary of operation
// RL1: irdy is asserted the cycle after devsel and local ready were both seen low.
// RL2: a data phase completes in any cycle with irdy and trdy both low.
// RL3: the remaining phase count drops by one the cycle after each completed phase.
// RL4: after an accepted word the next half goes onto ad[31:0] with its enables on the low command lines.
// RL5: after trdy the low-half strobe is asserted with the high-half strobe off.
// RL6: the following transfer asserts the high-half strobe with the low one off and takes the upper bits.
// RL7: the local master holds data and enables while neither strobe was asserted the cycle before.
// RL8: both strobes stay off until the first data phase completes.
// RL9: frame stays asserted through the burst and is released only on the final phase.
// RL10: on the last phase frame, wide request and both strobes are off while irdy stays on.
// RL11: in turnaround frame, wide request, ad and command lines are released and irdy deasserted.
// RL12: in turnaround the count is zero and the status reports bus termination, normal if completed.
// RL13: the target deasserts devsel and trdy in the turnaround cycle.
// RL14: in the idle cycle after turnaround irdy and both parity outputs are released.
// RL15: without the wide acknowledge the wide flag is dropped and the count rescaled to 32-bit phases.
// RL16: the local master asserts ready only when it can supply write data.
// RL17: low and high strobes keep alternating for each further local word until the count runs out.
module pmbw_core import pmbw_pkg::*; #(
   parameter int CNT_W = CNT_W_DEF,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [CNT_W-1:0] burst_length_i,
   input wire logic local_ready_n_i,
   input wire logic [WORD_W-1:0] local_data_i,
   input wire logic [WORD_BE_W-1:0] local_byte_enables_i,
   input wire logic devsel_n_i,
   input wire logic trdy_n_i,
   input wire logic ack64_n_i,
   output logic [DATA_W-1:0] ad_o,
   output logic ad_oe_o,
   output logic [BE_W-1:0] bus_cmd_be_n_o,
   output logic bus_cmd_be_oe_o,
   output logic frame_n_o,
   output logic frame_oe_o,
   output logic req64_n_o,
   output logic req64_oe_o,
   output logic irdy_n_o,
   output logic irdy_oe_o,
   output logic par_o,
   output logic par_oe_o,
   output logic par64_o,
   output logic par64_oe_o,
   output logic local_low_half_taken_n_o,
   output logic local_high_half_taken_n_o,
   output logic wide_transfer_flag_n_o,
   output logic [CNT_W-1:0] remaining_phase_count_o,
   output logic [3:0] initiator_state_code_o,
   output logic [2:0] termination_reason_o
);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PHASE_LAST);
   localparam logic [CNT_W-1:0] CNT_PRE = CNT_W'(HALVES_PRELOADED);
   localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(HALF_STEP);

   pmbw_half_if #(.W(HALF_W)) half ();

   pmbw_state_t state, next_state;
   logic [DATA_W-1:0] next_ad;
   logic [BE_W-1:0] next_be;
   logic next_ad_oe, next_frame_n, next_frame_oe, next_req64_n, next_req64_oe;
   logic next_irdy_n, next_irdy_oe, next_low_n, next_high_n, next_wide_n;
   logic [CNT_W-1:0] next_count, feed_left, next_feed_left;
   logic [3:0] next_code;
   logic [2:0] next_term;
   logic first_done, next_first_done, half_high, next_half_high;
   logic completed, push_now, fifo_pop, load_ok;

   // a phase completes whenever both ready lines are low
   assign completed = (state == ST_DATA) && !irdy_n_o && !trdy_n_i; // RL2
   // strobes are registered: the half is consumed in the cycle they show
   assign push_now = !local_low_half_taken_n_o || !local_high_half_taken_n_o;

   always_comb begin
      half.wvalid = 1'b0;
      half.wdata = {local_byte_enables_i[WORD_BE_W-1:BE_W], local_data_i[WORD_W-1:DATA_W]};
      if (state == ST_IDLE && start_i) begin
         half.wvalid = 1'b1;
      end else if (!local_low_half_taken_n_o) begin
         half.wvalid = 1'b1; // RL5
         half.wdata = {local_byte_enables_i[BE_W-1:0], local_data_i[DATA_W-1:0]};
      end else if (!local_high_half_taken_n_o) begin
         half.wvalid = 1'b1; // RL6
      end
      half.rready = fifo_pop;
   end

   pmbw_fifo #(.W(HALF_W), .DEPTH(FIFO_DEPTH)) i_pmbw_fifo (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .q(half)
   );

   pmbw_parity #(.W(HALF_W)) i_pmbw_parity (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .data_i({bus_cmd_be_n_o, ad_o}),
      .drive_i(ad_oe_o),
      .par_o(par_o),
      .par_oe_o(par_oe_o)
   );

   always_comb begin
      next_state = state;
      next_ad = ad_o;
      next_be = bus_cmd_be_n_o;
      next_ad_oe = ad_oe_o;
      next_frame_n = frame_n_o;
      next_frame_oe = frame_oe_o;
      next_req64_n = req64_n_o;
      next_req64_oe = req64_oe_o;
      next_irdy_n = irdy_n_o;
      next_irdy_oe = irdy_oe_o;
      next_low_n = 1'b1;
      next_high_n = 1'b1;
      next_wide_n = wide_transfer_flag_n_o;
      next_count = remaining_phase_count_o;
      next_code = initiator_state_code_o;
      next_term = termination_reason_o;
      next_feed_left = feed_left;
      next_first_done = first_done;
      next_half_high = half_high;
      fifo_pop = 1'b0;
      load_ok = half.rvalid;
      case (state)
         ST_IDLE: begin
            if (start_i) begin
               next_ad = local_data_i[DATA_W-1:0];
               next_be = local_byte_enables_i[BE_W-1:0];
               next_ad_oe = 1'b1;
               next_frame_n = 1'b0;
               next_frame_oe = 1'b1;
               next_req64_n = 1'b0;
               next_req64_oe = 1'b1;
               next_irdy_n = 1'b1;
               next_irdy_oe = 1'b1;
               next_wide_n = 1'b0;
               next_count = burst_length_i;
               next_feed_left = {burst_length_i[CNT_W-2:0], 1'b0} - CNT_PRE;
               next_first_done = 1'b0;
               next_half_high = 1'b0;
               next_code = CODE_BUS_TRANS;
               next_term = TERM_NONE;
               next_state = ST_DECIDE;
            end
         end
         ST_DECIDE: begin
            if (!devsel_n_i && !local_ready_n_i) begin
               next_irdy_n = 1'b0; // RL1
               // the data path is 32 bits wide whatever the answer
               next_count = {remaining_phase_count_o[CNT_W-2:0], 1'b0}; // RL15
               next_wide_n = ack64_n_i; // RL15
               next_state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (completed) begin
               next_first_done = 1'b1;
               next_count = remaining_phase_count_o - CNT_STEP; // RL3
               if (remaining_phase_count_o == CNT_LAST) begin
                  next_frame_oe = 1'b0; // RL11
                  next_req64_oe = 1'b0; // RL11
                  next_ad_oe = 1'b0; // RL11
                  next_irdy_n = 1'b1; // RL11
                  next_code = CODE_BUS_TERM; // RL12
                  next_term = TERM_NORMAL; // RL12
                  next_state = ST_TURN;
               end else if (load_ok) begin
                  next_ad = half.rdata[DATA_W-1:0]; // RL4
                  next_be = half.rdata[HALF_W-1:DATA_W]; // RL4
                  fifo_pop = 1'b1;
                  next_irdy_n = 1'b0;
               end else begin
                  // buffer ran dry: insert a wait state rather than send stale data
                  next_irdy_n = 1'b1;
               end
            end else if (irdy_n_o && load_ok) begin
               next_ad = half.rdata[DATA_W-1:0]; // RL4
               next_be = half.rdata[HALF_W-1:DATA_W];
               fifo_pop = 1'b1;
               next_irdy_n = 1'b0;
            end
            // frame may only drop while irdy is asserted, so a refill wait on the last phase keeps it
            if (next_state == ST_DATA && next_count == CNT_LAST && !next_irdy_n) begin
               next_frame_n = 1'b1; // RL9 RL10
               next_req64_n = 1'b1; // RL10
            end
            // strobe only after the first phase; a strobe is committed only with room for its push
            if ((first_done || completed) && feed_left != '0 && !local_ready_n_i // RL8
                && next_state == ST_DATA && next_count != CNT_LAST // RL10
                && (push_now ? half.room2 : half.wready)) begin
               if (half_high) begin
                  next_high_n = 1'b0; // RL6
               end else begin
                  next_low_n = 1'b0; // RL5
               end
               next_half_high = !half_high; // RL17
               next_feed_left = feed_left - CNT_STEP;
            end
         end
         ST_TURN: begin
            next_irdy_oe = 1'b0; // RL14
            next_code = CODE_IDLE;
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         ad_o <= '0;
         bus_cmd_be_n_o <= '1;
         ad_oe_o <= 1'b0;
         bus_cmd_be_oe_o <= 1'b0;
         frame_n_o <= 1'b1;
         frame_oe_o <= 1'b0;
         req64_n_o <= 1'b1;
         req64_oe_o <= 1'b0;
         irdy_n_o <= 1'b1;
         irdy_oe_o <= 1'b0;
         par64_o <= 1'b0;
         par64_oe_o <= 1'b0;
         local_low_half_taken_n_o <= 1'b1;
         local_high_half_taken_n_o <= 1'b1;
         wide_transfer_flag_n_o <= 1'b1;
         remaining_phase_count_o <= '0;
         initiator_state_code_o <= CODE_IDLE;
         termination_reason_o <= TERM_NONE;
         feed_left <= '0;
         first_done <= 1'b0;
         half_high <= 1'b0;
      end else begin
         state <= next_state;
         ad_o <= next_ad;
         bus_cmd_be_n_o <= next_be;
         ad_oe_o <= next_ad_oe;
         bus_cmd_be_oe_o <= next_ad_oe; // RL11
         frame_n_o <= next_frame_n;
         frame_oe_o <= next_frame_oe;
         req64_n_o <= next_req64_n;
         req64_oe_o <= next_req64_oe;
         irdy_n_o <= next_irdy_n;
         irdy_oe_o <= next_irdy_oe;
         // upper lanes are never driven here, so their parity is constant
         par64_o <= 1'b0;
         par64_oe_o <= req64_oe_o; // RL14
         local_low_half_taken_n_o <= next_low_n;
         local_high_half_taken_n_o <= next_high_n;
         wide_transfer_flag_n_o <= next_wide_n;
         remaining_phase_count_o <= next_count;
         initiator_state_code_o <= next_code;
         termination_reason_o <= next_term;
         feed_left <= next_feed_left;
         first_done <= next_first_done;
         half_high <= next_half_high;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   irdy_after_decide_a: assert property (state == ST_DECIDE && !devsel_n_i && !local_ready_n_i |=> !irdy_n_o) // RL1
      else $error("irdy not asserted after devsel and local ready");
   count_step_a: assert property (completed && remaining_phase_count_o > CNT_LAST
      |=> remaining_phase_count_o == $past(remaining_phase_count_o) - CNT_STEP) // RL3
      else $error("phase count did not drop after a completed phase");
   half_load_a: assert property (completed && remaining_phase_count_o > CNT_LAST && half.rvalid
      |=> ad_o == $past(half.rdata[DATA_W-1:0]) && bus_cmd_be_n_o == $past(half.rdata[HALF_W-1:DATA_W])) // RL4
      else $error("next half not placed on the bus after acceptance");
   strobe_hold_a: assert property (!first_done && !completed |=> local_low_half_taken_n_o && local_high_half_taken_n_o) // RL8
      else $error("strobe asserted before the first phase completed");
   strobe_alt_a: assert property (!local_low_half_taken_n_o |-> local_high_half_taken_n_o ##1 local_low_half_taken_n_o) // RL17
      else $error("low strobe repeated or overlapped high strobe");
   frame_last_a: assert property (state == ST_DATA && remaining_phase_count_o == CNT_LAST && !irdy_n_o
      |-> frame_n_o && req64_n_o && local_low_half_taken_n_o && local_high_half_taken_n_o) // RL10
      else $error("frame or strobes still asserted on the last phase");
   frame_burst_a: assert property (state == ST_DATA && remaining_phase_count_o > CNT_LAST |-> !frame_n_o && frame_oe_o) // RL9
      else $error("frame released before the final phase");
   turn_release_a: assert property (completed && remaining_phase_count_o == CNT_LAST
      |=> !frame_oe_o && !req64_oe_o && !ad_oe_o && irdy_n_o && remaining_phase_count_o == '0
      && initiator_state_code_o == CODE_BUS_TERM && termination_reason_o == TERM_NORMAL) // RL11
      else $error("turnaround cycle outputs wrong");
   idle_release_a: assert property (state == ST_TURN |=> !irdy_oe_o && !par_oe_o && !par64_oe_o) // RL14
      else $error("irdy or parity still driven after turnaround");
   rescale_a: assert property (state == ST_DECIDE && !devsel_n_i && !local_ready_n_i
      |=> remaining_phase_count_o == {$past(remaining_phase_count_o[CNT_W-2:0]), 1'b0}
      && wide_transfer_flag_n_o == $past(ack64_n_i)) // RL15
      else $error("count not rescaled at width decision");
endmodule // pmbw_core

// ### pmbw_pkg.sv
// Purpose: shared constants and types of the narrowing burst-write path
// Assumes: one PCI-side clock, synchronous active-high reset
// Notes: status and termination codes are local encodings
package pmbw_pkg;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int HALF_W = DATA_W + BE_W;
   localparam int WORD_W = 2 * DATA_W;
   localparam int WORD_BE_W = 2 * BE_W;
   localparam int CNT_W_DEF = 8;
   localparam int FIFO_DEPTH_DEF = 4;
   localparam int PHASE_LAST = 1;
   localparam int HALVES_PRELOADED = 2;
   localparam int HALF_STEP = 1;
   localparam logic [3:0] CODE_IDLE = 4'h0;
   localparam logic [3:0] CODE_BUS_TRANS = 4'h2;
   localparam logic [3:0] CODE_BUS_TERM = 4'h3;
   localparam logic [2:0] TERM_NONE = 3'h0;
   localparam logic [2:0] TERM_NORMAL = 3'h1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DECIDE = 2'h1,
      ST_DATA = 2'h2,
      ST_TURN = 2'h3
   } pmbw_state_t;
endpackage

// ### pmbw_half_if.sv
// Purpose: half-word stream between the core and its buffer
// Assumes: both ends on the same clock
// Notes: room2 lets the producer commit a strobe one cycle ahead of its push
interface pmbw_half_if #(parameter int W = 36);
   logic [W-1:0] wdata;
   logic wvalid;
   logic wready;
   logic room2;
   logic [W-1:0] rdata;
   logic rvalid;
   logic rready;
   modport src (output wdata, output wvalid, output rready, input wready, input room2, input rdata, input rvalid);
   modport buffer (input wdata, input wvalid, input rready, output wready, output room2, output rdata, output rvalid);
endinterface

// ### pmbw_fifo.sv
// Purpose: small first-in first-out buffer for half words
// Assumes: DEPTH is a power of two, at least 2
// Notes: full and empty come from an explicit level count
module pmbw_fifo #(
   parameter int W = 36,
   parameter int DEPTH = 4
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   pmbw_half_if.buffer q
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH + 1);
   localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
   localparam logic [LW-1:0] ROOM2_LEVEL = LW'(DEPTH - 2);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [LW-1:0] level, next_level;
   logic push, pop;

   assign q.wready = (level != FULL_LEVEL);
   assign q.room2 = (level <= ROOM2_LEVEL);
   assign q.rvalid = (level != '0);
   assign q.rdata = mem[rd_ptr];

   always_comb begin
      push = q.wvalid && q.wready;
      pop = q.rready && q.rvalid;
      next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
      next_level = level;
      if (push && !pop) begin
         next_level = level + LW'(1);
      end else if (pop && !push) begin
         next_level = level - LW'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level <= next_level;
      end
      if (push) begin
         mem[wr_ptr] <= q.wdata;
      end
   end
endmodule // pmbw_fifo

// ### pmbw_parity.sv
// Purpose: even parity over driven lines, one clock behind them
// Assumes: data and drive_i come from flip-flops of the same clock
// Notes: the enable lags the lines so parity is released a cycle later
module pmbw_parity #(
   parameter int W = 36
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] data_i,
   input wire logic drive_i,
   output logic par_o,
   output logic par_oe_o
);
   logic next_par;

   always_comb begin
      next_par = ^data_i;
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         par_o <= 1'b0;
         par_oe_o <= 1'b0;
      end else begin
         par_o <= next_par;
         par_oe_o <= drive_i;
      end
   end
endmodule // pmbw_parity

// ### pmbw_partner.sv
// Purpose: far-side model, a local master with 64-bit words and a 32-bit target
// Assumes: driven at the falling edge, design samples at the rising edge
// Notes: slow_i inserts target wait states and local not-ready cycles
module pmbw_partner import pmbw_pkg::*; (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic slow_i,
   input wire logic wide_ack_i,
   input wire logic frame_n_i,
   input wire logic frame_oe_i,
   input wire logic irdy_n_i,
   input wire logic irdy_oe_i,
   input wire logic high_taken_n_i,
   input wire logic [3:0] state_code_i,
   output logic local_ready_n_o,
   output logic [WORD_W-1:0] local_data_o,
   output logic [WORD_BE_W-1:0] local_byte_enables_o,
   output logic devsel_n_o,
   output logic trdy_n_o,
   output logic ack64_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] widx;
   logic tick;
   logic busy;

   function automatic logic [71:0] word(input int k);
      return {~4'(k), 4'(k), 32'ha500_0001 | 32'(k * 16), 32'h5a00_0000 | 32'(k * 16)};
   endfunction

   // the word stays until its upper half has been taken
   always @(posedge core_clk_i) begin
      if (reset_i || state_code_i == CODE_BUS_TERM) begin
         widx <= 8'h00;
      end else if (start_i && state_code_i == CODE_IDLE) begin
         widx <= 8'h01;
      end else if (!high_taken_n_i) begin
         widx <= widx + 8'h01;
      end
   end

   initial begin
      tick = 1'b0;
      devsel_n_o = 1'b1;
      trdy_n_o = 1'b1;
      ack64_n_o = 1'b1;
      local_ready_n_o = 1'b1;
      {local_byte_enables_o, local_data_o} = word(0);
   end

   // the target claims the cycle only while the master holds frame or irdy
   always @(negedge core_clk_i) begin
      busy = (frame_oe_i && !frame_n_i) || (irdy_oe_i && !irdy_n_i);
      tick <= ~tick;
      devsel_n_o <= !busy;
      trdy_n_o <= !busy || (slow_i && tick);
      ack64_n_o <= !(wide_ack_i && busy);
      local_ready_n_o <= slow_i && tick;
      {local_byte_enables_o, local_data_o} <= word(int'(widx));
   end
endmodule // pmbw_partner

// ### pmbw_core_bench.sv
// Purpose: self-checking bench of the narrowing burst-write path
// Assumes: inputs change at the falling edge, outputs sampled at the rising edge
// Notes: expected halves are rebuilt here from the word numbering of the partner
module pmbw_core_bench import pmbw_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, slow = 1'b0, wide = 1'b0;
   logic [7:0] burst_length_i = 8'h01;
   logic local_ready_n_i, devsel_n_i, trdy_n_i, ack64_n_i;
   logic [WORD_W-1:0] local_data_i;
   logic [WORD_BE_W-1:0] local_byte_enables_i;
   logic [DATA_W-1:0] ad_o;
   logic [BE_W-1:0] bus_cmd_be_n_o;
   logic ad_oe_o, bus_cmd_be_oe_o, frame_n_o, frame_oe_o, req64_n_o, req64_oe_o, irdy_n_o, irdy_oe_o;
   logic par_o, par_oe_o, par64_o, par64_oe_o, lo_n, hi_n, wide_transfer_flag_n_o;
   logic [7:0] cnt;
   logic [3:0] code;
   logic [2:0] termination_reason_o;
   int n_errors = 0;
   int check_count = 0;

   initial forever #12.5 core_clk_i = ~core_clk_i;

   pmbw_core i_pmbw_core (.core_clk_i(core_clk_i), .reset_i(reset_i), .start_i(start_i),
      .burst_length_i(burst_length_i), .local_ready_n_i(local_ready_n_i), .local_data_i(local_data_i),
      .local_byte_enables_i(local_byte_enables_i), .devsel_n_i(devsel_n_i), .trdy_n_i(trdy_n_i),
      .ack64_n_i(ack64_n_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .bus_cmd_be_n_o(bus_cmd_be_n_o),
      .bus_cmd_be_oe_o(bus_cmd_be_oe_o), .frame_n_o(frame_n_o), .frame_oe_o(frame_oe_o),
      .req64_n_o(req64_n_o), .req64_oe_o(req64_oe_o), .irdy_n_o(irdy_n_o), .irdy_oe_o(irdy_oe_o),
      .par_o(par_o), .par_oe_o(par_oe_o), .par64_o(par64_o), .par64_oe_o(par64_oe_o),
      .local_low_half_taken_n_o(lo_n), .local_high_half_taken_n_o(hi_n),
      .wide_transfer_flag_n_o(wide_transfer_flag_n_o), .remaining_phase_count_o(cnt),
      .initiator_state_code_o(code), .termination_reason_o(termination_reason_o));

   pmbw_partner i_pmbw_partner (.core_clk_i(core_clk_i), .reset_i(reset_i), .start_i(start_i),
      .slow_i(slow), .wide_ack_i(wide), .frame_n_i(frame_n_o), .frame_oe_i(frame_oe_o),
      .irdy_n_i(irdy_n_o), .irdy_oe_i(irdy_oe_o), .high_taken_n_i(hi_n), .state_code_i(code),
      .local_ready_n_o(local_ready_n_i), .local_data_o(local_data_i),
      .local_byte_enables_o(local_byte_enables_i), .devsel_n_o(devsel_n_i), .trdy_n_o(trdy_n_i),
      .ack64_n_o(ack64_n_i));

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   function automatic logic [35:0] exp_half(input int i);
      int k;
      k = i / 2;
      if (i % 2 == 0) return {4'(k), 32'h5a00_0000 | 32'(k * 16)};
      return {~4'(k), 32'ha500_0001 | 32'(k * 16)};
   endfunction

   task automatic t_reset;
      @(negedge core_clk_i);
      chk("reset enables", 64'h0, {ad_oe_o, bus_cmd_be_oe_o, frame_oe_o, req64_oe_o, irdy_oe_o, par_oe_o, par64_oe_o});
      chk("reset lines", 64'h1f, {frame_n_o, req64_n_o, irdy_n_o, lo_n, hi_n});
      chk("reset count and code", 64'h0, {cnt, code});
      $display("test reset done");
   endtask

   // one burst; dbl pulses a second start mid-burst, which must be ignored
   task automatic run_burst(input int len, input logic sl, input logic wd, input logic dbl);
      logic [35:0] got[$];
      int nstr, cyc;
      logic prev_comp, prev_dr, irdy_seen, done, comp;
      logic [7:0] prev_cnt;
      logic prev_ad_oe;
      logic [35:0] prev_bus;
      nstr = 0;
      prev_comp = 0;
      prev_dr = 0;
      irdy_seen = 0;
      done = 0;
      prev_cnt = 8'h00;
      prev_ad_oe = 1'b0;
      prev_bus = '0;
      @(negedge core_clk_i);
      slow = sl;
      wide = wd;
      start_i = 1'b1;
      burst_length_i = 8'(len);
      @(negedge core_clk_i);
      start_i = 1'b0;
      for (cyc = 0; cyc < 400 && !done; cyc++) begin
         @(posedge core_clk_i);
         if (prev_comp) chk("count step", 64'(prev_cnt - 8'h01), cnt);
         if (!irdy_seen && irdy_n_o === 1'b0) begin
            irdy_seen = 1;
            chk("irdy cause", 64'h1, prev_dr);
            chk("rescaled count", 64'(2 * len), cnt);
            chk("wide flag", 64'(!wd), wide_transfer_flag_n_o);
         end
         if (lo_n === 1'b0 || hi_n === 1'b0) begin
            chk("strobe after first phase", 64'h1, got.size() > 0);
            chk("strobe pair", 64'(nstr % 2 == 0 ? 2'b01 : 2'b10), {lo_n, hi_n});
            nstr++;
         end
         if (code === CODE_BUS_TRANS && irdy_seen && cnt > 8'h01) chk("frame held", 64'h0, frame_n_o);
         if (code === CODE_BUS_TRANS && irdy_seen && cnt === 8'h01 && irdy_n_o === 1'b0) begin
            chk("last phase lines", 64'hf, {frame_n_o, req64_n_o, lo_n, hi_n});
         end
         comp = irdy_oe_o === 1'b1 && irdy_n_o === 1'b0 && trdy_n_i === 1'b0;
         if (comp) begin
            chk("ad driven", 64'h3, {ad_oe_o, bus_cmd_be_oe_o});
            got.push_back({bus_cmd_be_n_o, ad_o});
         end
         // parity follows the driven lines one cycle late; upper lanes stay quiet
         if (prev_ad_oe) chk("parity", {1'b1, ^prev_bus, 1'b0}, {par_oe_o, par_o, par64_o});
         prev_comp = comp;
         prev_cnt = cnt;
         prev_dr = devsel_n_i === 1'b0 && local_ready_n_i === 1'b0;
         prev_ad_oe = ad_oe_o;
         prev_bus = {bus_cmd_be_n_o, ad_o};
         if (code === CODE_BUS_TERM) begin
            chk("turnaround lines", 64'h1, {frame_oe_o, req64_oe_o, ad_oe_o, bus_cmd_be_oe_o, irdy_n_o});
            chk("end count", 64'h0, cnt);
            chk("end reason", 64'(TERM_NORMAL), termination_reason_o);
            @(posedge core_clk_i);
            chk("idle release", 64'h0, {irdy_oe_o, par_oe_o, par64_oe_o, code});
            done = 1;
         end else if (dbl && cyc == 6) begin
            @(negedge core_clk_i);
            start_i = 1'b1;
         end else if (start_i) begin
            @(negedge core_clk_i);
            start_i = 1'b0;
         end
      end
      if (!done) begin
         chk("burst finished", 64'h1, 64'h0);
         give_verdict();
      end
      chk("phase total", 64'(2 * len), got.size());
      foreach (got[i]) chk("half on bus", exp_half(i), got[i]);
      chk("strobe total", 64'(2 * len - 2), nstr);
      $display("test burst of %0d words done, slow %0d", len, sl);
   endtask

   initial begin
      repeat (2) @(negedge core_clk_i);
      reset_i = 1'b0;
      t_reset();
      run_burst(1, 1'b0, 1'b0, 1'b0);
      run_burst(2, 1'b0, 1'b0, 1'b0);
      run_burst(3, 1'b1, 1'b1, 1'b1);
      give_verdict();
   end
endmodule // pmbw_core_bench
